// >>> rtl/epe_array.sv
// nonvolatile 512 byte array with program and erase operations
`timescale 1ns/100ps
module epe_array (
  input wire logic aclk,
  input wire logic op_go,
  input wire epe_pkg::epe_op_t op_kind,
  input wire logic [8:0] op_addr,
  input wire logic [7:0] op_data,
  input wire logic [8:0] rd_addr,
  output logic [7:0] rd_data
);
  import epe_pkg::*;
  typedef struct packed {
    logic [511:0][7:0] mem;
  } epe_arr_st_t;
  epe_arr_st_t st_q, st_d;

  // one operation per go pulse; contents survive reset
  always_comb begin
    st_d = st_q;
    if (op_go) begin
      for (int i = 0; i < 512; i++) begin
        case (op_kind)
          EPE_OP_PROG: if (9'(i) == op_addr) st_d.mem[i] = op_data;
          EPE_OP_ERASE_BYTE: if (9'(i) == op_addr) st_d.mem[i] = EPE_ERASED;
          EPE_OP_ERASE_BLOCK: begin
            if (9'(i) >> EPE_BLK_BIT == op_addr >> EPE_BLK_BIT) st_d.mem[i] = EPE_ERASED;
          end
          EPE_OP_ERASE_BULK: st_d.mem[i] = EPE_ERASED;
          default: st_d.mem[i] = st_q.mem[i];
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

  assign rd_data = st_q.mem[rd_addr];

  default clocking cb @(posedge aclk); endclocking
  bulk_erase_a: assert property (op_go && op_kind == EPE_OP_ERASE_BULK |=> &st_q.mem)
    else $error("bulk erase left bytes unerased");
endmodule : epe_array

// >>> rtl/epe_ctrl.sv
// eeprom program and erase controller with an axi4-lite register port
// Functional notes
// - array of 512 bytes sits at indices 0x200 to 0x3ff.
// - program and erase are steered only by the control register at 0x007.
// - oscillator enable starts pump oscillator; software waits at least 1 us.
// - oscillator disabled means pump clocked from the bus clock.
// - erase select 00 none, 01 byte, 10 block, 11 both blocks.
// - two 256 byte blocks; block erase hits the addressed block.
// - with latch and power set, erase select chooses erase or program.
// - latch set makes an array write capture address and data.
// - latch clear forces erase select and programming power to zero.
// - setting programming power is ignored unless latch already one.
// - array reads while latch is set return all ones.
// - write protection covers only the upper block.
// - option byte bit 1 one makes upper block writable, zero read only.
// - protect change takes effect only at the next reset.
// - option bit 0 disables low voltage reset, sampled at reset.
// - latch clear gives plain reads with the charge pump off.
// - program commits when power drops; latch clear needed per byte.
// - any erase touching the upper block is blocked while protected.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module epe_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic pump_tick,
  output logic pump_osc_ready,
  output logic program_power_on,
  output logic upper_block_writable,
  output logic low_voltage_reset_off
);
  import epe_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic aw_v;
    logic [9:0] aw_idx;
    logic aw_hi_ok;
    logic w_v;
    logic [7:0] w_data;
    logic w_lane0;
    logic b_v;
    logic [1:0] b_resp;
    logic r_v;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic [EPE_CTL_W-1:0] ctl;
    logic lat_v;
    logic spent;
    logic [8:0] lat_addr;
    logic [7:0] lat_data;
    logic sampled;
    logic prot;
    logic lvr_off;
  } epe_ctrl_st_t;

  epe_ctrl_st_t st_q, st_d;
  logic op_go;
  logic op_blocked;
  logic aw_hit;
  logic ar_hit;
  logic ctl_wr;
  logic arr_wr;
  logic [7:0] arr_rd;
  epe_op_t op_kind;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // index falls inside the array window
  function automatic logic in_array(input logic [9:0] idx);
    in_array = (idx >= EPE_ARR_LO_IDX) && (idx <= EPE_ARR_HI_IDX);
  endfunction : in_array

  // index names a mapped register or array byte
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == EPE_CTL_IDX) || in_array(idx);
  endfunction : is_mapped

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  // a write completes when both address and data are held
  assign aw_hit = st_q.aw_hi_ok && is_mapped(st_q.aw_idx);
  assign ar_hit = (araddr[31:12] == 20'h0) && is_mapped(araddr[11:2]);
  assign ctl_wr = st_q.aw_v && st_q.w_v && !st_q.b_v && aw_hit && st_q.w_lane0
    && (st_q.aw_idx == EPE_CTL_IDX);
  assign arr_wr = st_q.aw_v && st_q.w_v && !st_q.b_v && aw_hit && st_q.w_lane0
    && in_array(st_q.aw_idx);

  // the latched access runs as the mode picked by the select bits
  assign op_kind = epe_op_t'({st_q.ctl[EPE_ER1_BIT], st_q.ctl[EPE_ER0_BIT]});

  // upper block refused while the reset-sampled protect bit is zero
  always_comb begin
    op_blocked = 1'b0;
    if (!st_q.prot) begin
      if (op_kind == EPE_OP_ERASE_BULK) op_blocked = 1'b1;
      else if (st_q.lat_addr[EPE_BLK_BIT]) op_blocked = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    op_go = 1'b0;

    // option byte straps caught in the first cycle after reset release
    if (!st_q.sampled) begin
      st_d.sampled = 1'b1;
      st_d.prot = arr_rd[EPE_PROT_BIT];
      st_d.lvr_off = arr_rd[EPE_LVR_BIT];
    end

    // write address and data channels, taken in either order
    if (awvalid && awready) begin
      st_d.aw_v = 1'b1;
      st_d.aw_idx = awaddr[11:2];
      st_d.aw_hi_ok = (awaddr[31:12] == 20'h0);
    end
    if (wvalid && wready) begin
      st_d.w_v = 1'b1;
      st_d.w_data = wdata[7:0];
      st_d.w_lane0 = wstrb[0];
    end
    if (st_q.b_v && bready) st_d.b_v = 1'b0;

    // write execution and response
    if (st_q.aw_v && st_q.w_v && !st_q.b_v) begin
      st_d.aw_v = 1'b0;
      st_d.w_v = 1'b0;
      st_d.b_v = 1'b1;
      st_d.b_resp = aw_hit ? EPE_OKAY : EPE_SLVERR;
    end

    // control register write; only this path steers the array
    if (ctl_wr) begin
      st_d.ctl[EPE_OSC_BIT] = st_q.w_data[EPE_OSC_BIT];
      st_d.ctl[EPE_LAT_BIT] = st_q.w_data[EPE_LAT_BIT];
      if (st_q.w_data[EPE_LAT_BIT]) begin
        st_d.ctl[EPE_ER1_BIT] = st_q.w_data[EPE_ER1_BIT];
        st_d.ctl[EPE_ER0_BIT] = st_q.w_data[EPE_ER0_BIT];
        st_d.ctl[EPE_PGM_BIT] = st_q.w_data[EPE_PGM_BIT] & st_q.ctl[EPE_LAT_BIT];
      end else begin
        st_d.ctl[EPE_ER1_BIT] = 1'b0;
        st_d.ctl[EPE_ER0_BIT] = 1'b0;
        st_d.ctl[EPE_PGM_BIT] = 1'b0;
        st_d.lat_v = 1'b0;
        st_d.spent = 1'b0;
      end
    end

    // array write with the latch set captures address and data once
    if (arr_wr && st_q.ctl[EPE_LAT_BIT] && !st_q.spent) begin
      st_d.lat_v = 1'b1;
      st_d.spent = 1'b1;
      st_d.lat_addr = st_q.aw_idx[8:0];
      st_d.lat_data = st_q.w_data;
    end

    // the captured access commits when programming power is removed
    if (st_q.ctl[EPE_PGM_BIT] && !st_d.ctl[EPE_PGM_BIT] && st_q.lat_v) begin
      st_d.lat_v = 1'b0;
      op_go = !op_blocked;
    end

    // read channel
    if (st_q.r_v && rready) st_d.r_v = 1'b0;
    if (arvalid && arready) begin
      st_d.r_v = 1'b1;
      st_d.r_resp = ar_hit ? EPE_OKAY : EPE_SLVERR;
      if (!ar_hit) begin
        st_d.r_data = 32'h0;
      end else if (araddr[11:2] == EPE_CTL_IDX) begin
        st_d.r_data = {27'h0, st_q.ctl};
      end else if (st_q.ctl[EPE_LAT_BIT]) begin
        st_d.r_data = {24'h0, EPE_BUSY_READ};
      end else begin
        st_d.r_data = {24'h0, arr_rd};
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.ctl <= EPE_CTL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // handshake readies block while an answer waits
  assign awready = !st_q.aw_v && !st_q.b_v;
  assign wready = !st_q.w_v && !st_q.b_v;
  assign arready = !st_q.r_v;
  assign bvalid = st_q.b_v;
  assign bresp = st_q.b_resp;
  assign rvalid = st_q.r_v;
  assign rdata = st_q.r_data;
  assign rresp = st_q.r_resp;
  assign program_power_on = st_q.ctl[EPE_PGM_BIT];
  assign upper_block_writable = st_q.prot;
  assign low_voltage_reset_off = st_q.lvr_off;

  // -----------------------------------------------------------------
  // submodules
  // -----------------------------------------------------------------
  // array read port follows the read address, or the option byte at release
  epe_array u_array (
    .aclk(aclk),
    .op_go(op_go),
    .op_kind(op_kind),
    .op_addr(st_q.lat_addr),
    .op_data(st_q.lat_data),
    .rd_addr(st_q.sampled ? araddr[10:2] : EPE_OPT_ADDR),
    .rd_data(arr_rd)
  );

  // pump clock source; pump is powered only by the power bit
  epe_pump_clk u_pump (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_enable(st_q.ctl[EPE_OSC_BIT]),
    .pump_power(st_q.ctl[EPE_PGM_BIT]),
    .pump_tick(pump_tick),
    .osc_ready(pump_osc_ready)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence latched_read_s;
    arvalid && arready && ar_hit && araddr[11:2] != EPE_CTL_IDX && st_q.ctl[EPE_LAT_BIT];
  endsequence
  sequence write_pair_s;
    st_q.aw_v && st_q.w_v && !st_q.b_v;
  endsequence

  unlatched_forced_a: assert property (!st_q.ctl[EPE_LAT_BIT] |-> st_q.ctl[3:0] == 4'h0)
    else $error("select or power set with latch clear");
  power_needs_lat_a: assert property ($rose(st_q.ctl[EPE_PGM_BIT]) |->
    $past(st_q.ctl[EPE_LAT_BIT]))
    else $error("power set without prior latch");
  busy_read_a: assert property (latched_read_s |=> rvalid && rdata == 32'h000000ff)
    else $error("latched read not all ones");
  protect_block_a: assert property (op_go |-> st_q.prot || !(st_q.lat_addr[EPE_BLK_BIT]
    || op_kind == EPE_OP_ERASE_BULK))
    else $error("protected upper block modified");
  capture_once_a: assert property ($rose(st_q.lat_v) |-> $past(st_q.ctl[EPE_LAT_BIT])
    && !$past(st_q.spent))
    else $error("capture without latch or twice");
  strap_stable_a: assert property (st_q.sampled && $past(st_q.sampled) |->
    $stable(st_q.prot) && $stable(st_q.lvr_off))
    else $error("option straps changed without reset");
  write_answer_a: assert property (write_pair_s |=> bvalid
    && bresp == (($past(aw_hit)) ? EPE_OKAY : EPE_SLVERR))
    else $error("write answer missing or wrong");
  ctl_read_a: assert property (arvalid && arready && ar_hit && araddr[11:2] == EPE_CTL_IDX
    |=> rdata[31:5] == 27'h0)
    else $error("unused control bits read nonzero");
  ctl_reset_a: assert property ($rose(aresetn) |-> st_q.ctl == EPE_CTL_RESET)
    else $error("control not cleared by reset");
endmodule : epe_ctrl

// >>> rtl/epe_pump_clk.sv
// charge pump clock source with oscillator settle timer
`timescale 1ns/100ps
module epe_pump_clk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_enable,
  input wire logic pump_power,
  output logic pump_tick,
  output logic osc_ready
);
  import epe_pkg::*;
  typedef struct packed {
    logic [1:0] div;
    logic [6:0] settle;
    logic ready;
  } epe_osc_st_t;
  epe_osc_st_t st_q, st_d;

  // internal oscillator model: divider and settle count while enabled
  always_comb begin
    st_d = st_q;
    if (!osc_enable) begin
      st_d = '0;
    end else begin
      st_d.div = (st_q.div == EPE_PUMP_DIV_LAST) ? 2'h0 : st_q.div + 2'h1;
      if (st_q.settle != EPE_SETTLE_CYC) st_d.settle = st_q.settle + 7'h1;
      st_d.ready = (st_q.settle == EPE_SETTLE_CYC);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st_q <= '0;
    else st_q <= st_d;
  end

  // pump runs only with power on; bus clock when the oscillator is off
  assign pump_tick = pump_power & (osc_enable ? (st_q.div == 2'h0) : 1'b1);
  assign osc_ready = st_q.ready;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  osc_settle_a: assert property (osc_ready |-> st_q.settle == EPE_SETTLE_CYC)
    else $error("oscillator ready before settle time");
  bus_clock_pump_a: assert property (!osc_enable && pump_power |-> pump_tick)
    else $error("pump not clocked by bus clock");
  pump_off_a: assert property (!pump_power |-> !pump_tick)
    else $error("pump ticking without programming power");
endmodule : epe_pump_clk

// >>> shared/epe_pkg.sv
// constants and types of the eeprom program and erase controller
package epe_pkg;
  // -----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [9:0] EPE_CTL_IDX = 10'h007;
  localparam logic [9:0] EPE_ARR_LO_IDX = 10'h200;
  localparam logic [9:0] EPE_ARR_HI_IDX = 10'h3ff;
  localparam logic [8:0] EPE_OPT_ADDR = 9'h000;
  localparam int EPE_AW = 9;
  localparam int EPE_BLK_BIT = 8;
  // -----------------------------------------------------------------
  // control and option fields
  // -----------------------------------------------------------------
  localparam int EPE_PGM_BIT = 0;
  localparam int EPE_LAT_BIT = 1;
  localparam int EPE_ER0_BIT = 2;
  localparam int EPE_ER1_BIT = 3;
  localparam int EPE_OSC_BIT = 4;
  localparam int EPE_CTL_W = 5;
  localparam logic [4:0] EPE_CTL_RESET = 5'h00;
  localparam int EPE_PROT_BIT = 1;
  localparam int EPE_LVR_BIT = 0;
  localparam logic [7:0] EPE_BUSY_READ = 8'hff;
  localparam logic [7:0] EPE_ERASED = 8'hff;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int EPE_CLK_NS = 10;
  localparam int EPE_SETTLE_NS = 1000;
  localparam int EPE_SETTLE_INT = (EPE_SETTLE_NS + EPE_CLK_NS - 1) / EPE_CLK_NS;
  localparam logic [6:0] EPE_SETTLE_CYC = 7'(EPE_SETTLE_INT);
  localparam logic [1:0] EPE_PUMP_DIV_LAST = 2'h3;
  // -----------------------------------------------------------------
  // bus answers and operations
  // -----------------------------------------------------------------
  localparam logic [1:0] EPE_OKAY = 2'h0;
  localparam logic [1:0] EPE_SLVERR = 2'h2;
  // order follows the erase-select code: 00 program, 01 byte, 10 block, 11 bulk
  typedef enum logic [1:0] {
    EPE_OP_PROG,
    EPE_OP_ERASE_BYTE,
    EPE_OP_ERASE_BLOCK,
    EPE_OP_ERASE_BULK
  } epe_op_t;
endpackage : epe_pkg

// >>> sim/tb_top.sv
// self-checking bench for the eeprom program and erase controller
`timescale 1ns/100ps
module tb_top;
  import epe_pkg::*;
  // ---------------------------------------------------------------
  // signals, queues and counters
  // ---------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [3:0] wr_strb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic pump_tick, pump_osc_ready, program_power_on, upper_block_writable;
  logic low_voltage_reset_off;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int n_errors = 0;
  int compares = 0;
  localparam logic [11:0] CTL_A = {EPE_CTL_IDX, 2'b00};
  localparam logic [11:0] BAD_A = 12'h020;
  // 100 mhz bus clock
  always #5 aclk = ~aclk;
  epe_ctrl epe_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pump_tick(pump_tick), .pump_osc_ready(pump_osc_ready),
    .program_power_on(program_power_on), .upper_block_writable(upper_block_writable),
    .low_voltage_reset_off(low_voltage_reset_off));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] arr_a(input int i);
    return {EPE_ARR_LO_IDX + 10'(i), 2'b00};
  endfunction : arr_a
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= {20'h0, a};
    wdata <= {24'($urandom()), d};
    wstrb <= wr_strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_r.push_back({r, 24'h0, d});
    @(posedge aclk);
    araddr <= {20'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  // code 0 programs, other codes erase with that select value
  task automatic op(input logic [1:0] code, input int i, input logic [7:0] d);
    wr(CTL_A, {4'h0, code, 2'b10}, EPE_OKAY);
    wr(arr_a(i), d, EPE_OKAY);
    wr(CTL_A, {4'h0, code, 2'b11}, EPE_OKAY);
    wr(CTL_A, 8'h00, EPE_OKAY);
  endtask : op
  task automatic do_reset(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : do_reset
  task automatic cnt_tick(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge aclk);
      if (pump_tick === 1'b1) c++;
    end
  endtask : cnt_tick
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ---------------------------------------------------------------
  // response monitor: oldest note against each answer
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) begin
      if (exp_b.size() == 0) chk(8'hee, 8'h00);
      else chk({6'h0, bresp}, {6'h0, exp_b.pop_front()});
    end
    if (rvalid === 1'b1 && rready) begin
      if (exp_r.size() == 0) chk(8'hee, 8'h00);
      else begin
        compares++;
        if ({rresp, rdata} !== exp_r[0]) begin
          n_errors++;
          $display("MISMATCH t=%0t read %h expected %h", $time, {rresp, rdata}, exp_r[0]);
        end
        void'(exp_r.pop_front());
      end
    end
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i, c;
    logic [7:0] d, d2;
    for (int k = 0; k < 512; k++) epe_ctrl_i.u_array.st_q.mem[k] = EPE_ERASED;
    epe_ctrl_i.u_array.st_q.mem[0] = 8'h02;
    void'($urandom(32'h9b465f36));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    i = 1 + $urandom_range(253);
    d = 8'($urandom()) & 8'h7f;
    d2 = 8'($urandom()) & 8'h7f;
    chk({7'h0, upper_block_writable}, 8'h01);
    chk({7'h0, low_voltage_reset_off}, 8'h00);
    rd(CTL_A, 8'h00, EPE_OKAY);
    rd(BAD_A, 8'h00, EPE_SLVERR);
    wr(BAD_A, 8'h5a, EPE_SLVERR);
    wr(CTL_A, 8'h0d, EPE_OKAY);
    rd(CTL_A, 8'h00, EPE_OKAY);
    wr(CTL_A, 8'hff, EPE_OKAY);
    rd(CTL_A, 8'h1e, EPE_OKAY);
    wr_strb = 4'h0;
    wr(CTL_A, 8'h00, EPE_OKAY);
    wr_strb = 4'hf;
    rd(CTL_A, 8'h1e, EPE_OKAY);
    wr(CTL_A, 8'h00, EPE_OKAY);
    // program one byte step by step
    wr(CTL_A, 8'h02, EPE_OKAY);
    wr(arr_a(i), d, EPE_OKAY);
    rd(arr_a(i), EPE_BUSY_READ, EPE_OKAY);
    wr(arr_a(i), ~d, EPE_OKAY);
    wr(CTL_A, 8'h03, EPE_OKAY);
    chk({7'h0, program_power_on}, 8'h01);
    wr(CTL_A, 8'h00, EPE_OKAY);
    chk({7'h0, program_power_on}, 8'h00);
    rd(arr_a(i), d, EPE_OKAY);
    wr(arr_a(i), 8'h55, EPE_OKAY);
    rd(arr_a(i), d, EPE_OKAY);
    // capture without power commits nothing
    wr(CTL_A, 8'h02, EPE_OKAY);
    wr(arr_a(i + 1), d2, EPE_OKAY);
    wr(CTL_A, 8'h00, EPE_OKAY);
    rd(arr_a(i + 1), EPE_ERASED, EPE_OKAY);
    // byte, block and bulk erase
    op(2'h0, i + 1, d2);
    op(2'h1, i, 8'h33);
    rd(arr_a(i), EPE_ERASED, EPE_OKAY);
    rd(arr_a(i + 1), d2, EPE_OKAY);
    op(2'h0, 300, d);
    op(2'h2, i, 8'h00);
    rd(arr_a(i + 1), EPE_ERASED, EPE_OKAY);
    rd(arr_a(300), d, EPE_OKAY);
    op(2'h0, i, d);
    op(2'h3, 400, 8'h00);
    rd(arr_a(i), EPE_ERASED, EPE_OKAY);
    rd(arr_a(300), EPE_ERASED, EPE_OKAY);
    // option byte takes effect only at the next reset
    op(2'h0, 0, 8'h01);
    chk({7'h0, upper_block_writable}, 8'h01);
    chk({7'h0, low_voltage_reset_off}, 8'h00);
    wr(CTL_A, 8'h12, EPE_OKAY);
    do_reset(5);
    chk({7'h0, upper_block_writable}, 8'h00);
    chk({7'h0, low_voltage_reset_off}, 8'h01);
    rd(CTL_A, 8'h00, EPE_OKAY);
    // upper block protected, lower block still free
    op(2'h0, 300, d);
    rd(arr_a(300), EPE_ERASED, EPE_OKAY);
    op(2'h0, i, d);
    rd(arr_a(i), d, EPE_OKAY);
    op(2'h3, i, 8'h00);
    rd(arr_a(i), d, EPE_OKAY);
    op(2'h2, i, 8'h00);
    rd(arr_a(i), EPE_ERASED, EPE_OKAY);
    // charge pump clocking
    wr(CTL_A, 8'h02, EPE_OKAY);
    wr(CTL_A, 8'h03, EPE_OKAY);
    cnt_tick(8, c);
    chk(8'(c), 8'h08);
    wr(CTL_A, 8'h13, EPE_OKAY);
    repeat (60) @(negedge aclk);
    chk({7'h0, pump_osc_ready}, 8'h00);
    repeat (50) @(negedge aclk);
    chk({7'h0, pump_osc_ready}, 8'h01);
    cnt_tick(40, c);
    chk(8'(c), 8'h0a);
    wr(CTL_A, 8'h00, EPE_OKAY);
    cnt_tick(8, c);
    chk(8'(c), 8'h00);
    repeat (4) @(posedge aclk);
    chk(8'(exp_b.size() + exp_r.size()), 8'h00);
    give_verdict();
  end
endmodule : tb_top
